/* File: design/p5g_pkg.sv */
// Purpose: Shared constants and types of the port 5 GPIO / wakeup / segment block
// Assumes: Byte-wide register port, one 100 MHz clock
// Notes:   Register offsets are word indices on the plain register port
package p5g_pkg;

  localparam int          P5G_W      = 8;
  localparam int          P5G_AW     = 3;

  // Register map
  localparam logic [2:0]  A_DATA     = 3'h0;
  localparam logic [2:0]  A_DIR      = 3'h1;
  localparam logic [2:0]  A_PULL     = 3'h2;
  localparam logic [2:0]  A_MODE     = 3'h3;
  localparam logic [2:0]  A_STAT     = 3'h4;
  localparam logic [2:0]  A_MASK     = 3'h5;

  // Reset and fixed read values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  ALL_ONES   = 8'hff;
  localparam logic [7:0]  WAKE_IDLE  = 8'hff;

  // Segment-select ranges per nibble
  localparam logic [3:0]  SEG_HI_MIN = 4'h2;
  localparam logic [3:0]  SEG_HI_MAX = 4'h9;
  localparam logic [3:0]  SEG_LO_MIN = 4'h1;
  localparam logic [3:0]  SEG_LO_MAX = 4'h8;

  // Operating modes
  typedef enum logic [2:0] {
    PM_ACTIVE,
    PM_SUBACTIVE,
    PM_SLEEP,
    PM_SUBSLEEP,
    PM_STANDBY,
    PM_WATCH
  } p5g_pmode_t;

  // Whole state of the port
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] pull;
    logic [7:0] mode;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [7:0] rdata;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl;
    logic [7:0] hout;
    logic [7:0] hoe;
  } p5g_state_t;

endpackage

/* File: design/p5g_port_top.sv */
// Purpose: Port 5 pins with GPIO, wakeup input and LCD segment functions
// Assumes: Segment field and segment data come from logic on i_clk
// Notes:   Pin value and enable are registered and follow register writes one cycle later when functional; standby and watch force the enable off at once
//
// Design decisions made here: the placing of the registers and the strobed register port.

`timescale 1ns/100ps

module p5g_port_top
  import p5g_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire logic [P5G_AW-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  input  wire p5g_pmode_t        i_power_mode,
  input  wire logic [3:0]        i_lcd_pin_assign_field,
  input  wire logic [7:0]        i_lcd_drive_out,
  input  wire logic [7:0]        i_gpio_pin,
  output logic      [7:0]        o_gpio_pin,
  output logic      [7:0]        o_gpio_pin_oe,
  output logic      [7:0]        o_pullup_en,
  output logic      [7:0]        o_wakeup,
  output logic                   o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Pins taken over as segment outputs
  function automatic logic [7:0] seg_mask(input logic [3:0] f);
    logic hi;
    logic lo;
    hi = (f >= SEG_HI_MIN) && (f <= SEG_HI_MAX);
    lo = (f >= SEG_LO_MIN) && (f <= SEG_LO_MAX);
    return {{4{hi}}, {4{lo}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  p5g_state_t s_q;
  p5g_state_t s_d;

  logic [7:0] seg;
  logic [7:0] wsel;
  logic [7:0] gpio;
  logic [7:0] drv_out;
  logic [7:0] drv_oe;
  logic [7:0] fall;
  logic [7:0] clr;
  logic       func;
  logic       hold;
  logic       hiz;

  always_comb begin
    seg  = seg_mask(i_lcd_pin_assign_field);
    wsel = s_q.mode & ~seg;
    gpio = ~s_q.mode & ~seg;
    func = (i_power_mode == PM_ACTIVE) || (i_power_mode == PM_SUBACTIVE);
    hold = (i_power_mode == PM_SLEEP) || (i_power_mode == PM_SUBSLEEP);
    hiz  = (i_power_mode == PM_STANDBY) || (i_power_mode == PM_WATCH);
  end

  // Per-pin drive: segment first, then wakeup, then GPIO
  always_comb begin
    drv_out = (seg & i_lcd_drive_out) | (gpio & s_q.data);
    drv_oe  = seg | (gpio & s_q.dir);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;

    // Pin sampling; level changes once stages two and three agree
    s_d.s1 = i_gpio_pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < P5G_W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.lvl[i] = s_q.s3[i];
      end
    end

    // Register writes
    if (i_wr) begin
      case (i_addr)
        A_DATA: begin
          s_d.data = i_wdata;
        end
        A_DIR: begin
          s_d.dir = i_wdata;
        end
        A_PULL: begin
          s_d.pull = i_wdata;
        end
        A_MODE: begin
          s_d.mode = i_wdata;
        end
        A_MASK: begin
          s_d.mask = i_wdata;
        end
        default: begin
        end
      endcase
    end

    // Wakeup falling edges set sticky status; set wins over clear
    fall   = wsel & s_q.lvl & ~s_d.lvl;
    clr    = (i_wr && (i_addr == A_STAT)) ? i_wdata : RST_BYTE;
    s_d.stat = (s_q.stat & ~clr) | fall;

    // Read data one cycle after the strobe
    s_d.rdata = RST_BYTE;
    if (i_rd) begin
      case (i_addr)
        A_DATA: begin
          s_d.rdata = (s_q.dir & s_q.data) | (~s_q.dir & s_q.lvl);
        end
        A_DIR: begin
          s_d.rdata = ALL_ONES;
        end
        A_PULL: begin
          s_d.rdata = s_q.pull;
        end
        A_MODE: begin
          s_d.rdata = s_q.mode;
        end
        A_STAT: begin
          s_d.rdata = s_q.stat;
        end
        A_MASK: begin
          s_d.rdata = s_q.mask;
        end
        default: begin
          s_d.rdata = RST_BYTE;
        end
      endcase
    end

    // Drive follows setup when functional, is frozen in sleep modes
    if (func) begin
      s_d.hout = drv_out;
      s_d.hoe  = drv_oe;
    end else if (hiz) begin
      s_d.hoe  = RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    o_rdata       = s_q.rdata;
    o_gpio_pin    = s_q.hout;
    o_gpio_pin_oe = hiz ? RST_BYTE : s_q.hoe;
    o_pullup_en   = ~s_q.dir & s_q.pull;
    o_wakeup      = (wsel & s_q.lvl) | (~wsel & WAKE_IDLE);
    o_irq         = |(s_q.stat & s_q.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_dir_reads_ones;
    i_rd && (i_addr == A_DIR) |=> o_rdata == ALL_ONES;
  endproperty
  a_dir_reads_ones: assert property (p_dir_reads_ones)
    else $error("direction read not all ones");

  property p_read_latched;
    i_rd && (i_addr == A_DATA)
      |=> (o_rdata & $past(s_q.dir)) == ($past(s_q.data) & $past(s_q.dir));
  endproperty
  a_read_latched: assert property (p_read_latched)
    else $error("output pin read not latched data");

  property p_read_pin;
    i_rd && (i_addr == A_DATA)
      |=> (o_rdata & ~$past(s_q.dir)) == ($past(s_q.lvl) & ~$past(s_q.dir));
  endproperty
  a_read_pin: assert property (p_read_pin)
    else $error("input pin read not pin level");

  property p_pull_off_out;
    i_wr && (i_addr == A_DIR) && (i_wdata == ALL_ONES) |=> o_pullup_en == RST_BYTE;
  endproperty
  a_pull_off_out: assert property (p_pull_off_out)
    else $error("pull-up on for output pin");

  property p_hiz;
    hiz |-> o_gpio_pin_oe == RST_BYTE;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("pin driven in standby or watch");

  property p_sleep_hold;
    hold && $past(hold) |-> $stable(o_gpio_pin) && $stable(o_gpio_pin_oe);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("pin state changed in sleep");

  property p_seg_drive;
    func && $past(func) && ($past(i_lcd_pin_assign_field) == SEG_HI_MIN)
      |-> o_gpio_pin_oe == ALL_ONES && o_gpio_pin == $past(i_lcd_drive_out);
  endproperty
  a_seg_drive: assert property (p_seg_drive)
    else $error("segment pins not driven");

  property p_wake_undriven;
    func && $past(func) && ($past(s_q.mode) == ALL_ONES)
      && ($past(i_lcd_pin_assign_field) == RST_BYTE[3:0]) |-> o_gpio_pin_oe == RST_BYTE;
  endproperty
  a_wake_undriven: assert property (p_wake_undriven)
    else $error("wakeup pin driven");

  property p_wake_fwd;
    1'b1 |=> ((o_wakeup ^ $past(s_q.s3)) & wsel & $past(wsel & (s_q.s2 ~^ s_q.s3)))
      == RST_BYTE;
  endproperty
  a_wake_fwd: assert property (p_wake_fwd)
    else $error("wakeup level not forwarded");

  property p_irq;
    |(fall & s_q.mask) ##1 1 |-> o_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked wakeup edge gave no interrupt");

  property p_write_next;
    i_wr && (i_addr == A_PULL) |=> s_q.pull == $past(i_wdata);
  endproperty
  a_write_next: assert property (p_write_next)
    else $error("write not applied next cycle");

  property p_data_write;
    i_wr && (i_addr == A_DATA) |=> s_q.data == $past(i_wdata);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("data register write lost");

  property p_dir_write;
    i_wr && (i_addr == A_DIR) |=> s_q.dir == $past(i_wdata);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction register write lost");

  property p_mode_write;
    i_wr && (i_addr == A_MODE) |=> s_q.mode == $past(i_wdata);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode register write lost");

  property p_mode_read;
    i_rd && (i_addr == A_MODE) |=> o_rdata == $past(s_q.mode);
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode register read wrong");

  property p_pull_read;
    i_rd && (i_addr == A_PULL) |=> o_rdata == $past(s_q.pull);
  endproperty
  a_pull_read: assert property (p_pull_read)
    else $error("pull-up register read wrong");

  property p_pull_in;
    i_wr && (i_addr == A_DIR) && (i_wdata == RST_BYTE) |=> o_pullup_en == s_q.pull;
  endproperty
  a_pull_in: assert property (p_pull_in)
    else $error("pull-up off for input pin");

  property p_dir_read_keeps;
    i_rd && (i_addr == A_DIR) |=> $stable(s_q.dir);
  endproperty
  a_dir_read_keeps: assert property (p_dir_read_keeps)
    else $error("direction read disturbed register");

  property p_wake_oe;
    func && $past(func) |-> (o_gpio_pin_oe & $past(s_q.mode & ~seg)) == RST_BYTE;
  endproperty
  a_wake_oe: assert property (p_wake_oe)
    else $error("wakeup pin driven");

  property p_stat_set;
    |fall |=> (s_q.stat & $past(fall)) == $past(fall);
  endproperty
  a_stat_set: assert property (p_stat_set)
    else $error("wakeup edge not latched");

  property p_stat_clear;
    i_wr && (i_addr == A_STAT)
      |=> (s_q.stat & $past(i_wdata) & ~$past(fall)) == RST_BYTE;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status bit not cleared");

  property p_lvl_hold;
    1'b1 |=> ((s_q.lvl ^ $past(s_q.lvl)) & $past(s_q.s2 ^ s_q.s3)) == RST_BYTE;
  endproperty
  a_lvl_hold: assert property (p_lvl_hold)
    else $error("pin level taken before stages agree");

  property p_hiz_clears;
    hiz |=> s_q.hoe == RST_BYTE;
  endproperty
  a_hiz_clears: assert property (p_hiz_clears)
    else $error("drive enable kept in standby or watch");

  property p_gpio_oe;
    func && $past(func) && ($past(seg) == RST_BYTE) && ($past(s_q.mode) == RST_BYTE)
      |-> o_gpio_pin_oe == $past(s_q.dir);
  endproperty
  a_gpio_oe: assert property (p_gpio_oe)
    else $error("GPIO drive enable not from direction");

  property p_gpio_out;
    func && $past(func) && ($past(seg) == RST_BYTE) && ($past(s_q.mode) == RST_BYTE)
      |-> o_gpio_pin == $past(s_q.data);
  endproperty
  a_gpio_out: assert property (p_gpio_out)
    else $error("GPIO output not from data register");

  property p_seg_low;
    func && $past(func) && ($past(i_lcd_pin_assign_field) == SEG_LO_MIN)
      |-> (o_gpio_pin_oe[3:0] == ALL_ONES[3:0])
        && (o_gpio_pin[3:0] == $past(i_lcd_drive_out[3:0]));
  endproperty
  a_seg_low: assert property (p_seg_low)
    else $error("lower segment pins not driven");

  property p_seg_hi;
    func && $past(func) && ($past(i_lcd_pin_assign_field) == SEG_HI_MAX)
      |-> (o_gpio_pin_oe[7:4] == ALL_ONES[3:0])
        && (o_gpio_pin[7:4] == $past(i_lcd_drive_out[7:4]));
  endproperty
  a_seg_hi: assert property (p_seg_hi)
    else $error("upper segment pins not driven");

  property p_seg_off;
    func && $past(func) && ($past(i_lcd_pin_assign_field) > SEG_HI_MAX)
      |-> (o_gpio_pin_oe & ~$past(s_q.dir)) == RST_BYTE;
  endproperty
  a_seg_off: assert property (p_seg_off)
    else $error("segment drive outside field range");

endmodule

/* File: dv/p5g_pad_model.sv */
// Purpose: Pad model of the port 5 pins and the world beyond them
// Assumes: External driver yields to the block's own drive
// Notes:   Undriven pin without pull-up toggles, so no stale level passes
`timescale 1ns/100ps

module p5g_pad_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pull,
  input  wire logic [7:0] i_ext,
  input  wire logic       i_ext_en,
  output logic      [7:0] o_lvl
);
  logic [7:0] last_q;

  always_ff @(posedge i_clk) begin
    last_q <= o_lvl;
  end

  // Block drive, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++)
      o_lvl[i] = i_oe[i] ? i_out[i] : i_ext_en ? i_ext[i] : i_pull[i] ? 1'b1 : ~last_q[i];
  end
endmodule

/* File: dv/p5g_port_top_tb_top.sv */
// Purpose: Self-checking bench of the port 5 block
// Assumes: Pad model closes the loop from pin drive to pin level
// Notes:   Register bus driven just after rising edges
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("Error %0t: got %h exp %h", $time, (a), (b)); end end

module p5g_port_top_tb_top;
  import p5g_pkg::*;
  logic       clk, reset_n, wr, rd, ext_en, irq;
  logic [2:0] addr;
  logic [3:0] field;
  logic [7:0] wdata, rdata, seg, ext, pin, out, oe, pull, wake, rv, m;
  p5g_pmode_t pm;
  int         failures, num_checks;

  p5g_port_top i_p5g_port_top (.i_clk(clk), .i_reset_n(reset_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_power_mode(pm),
    .i_lcd_pin_assign_field(field), .i_lcd_drive_out(seg), .i_gpio_pin(pin),
    .o_gpio_pin(out), .o_gpio_pin_oe(oe), .o_pullup_en(pull), .o_wakeup(wake), .o_irq(irq));

  p5g_pad_model i_p5g_pad_model (.i_clk(clk), .i_out(out), .i_oe(oe), .i_pull(pull),
    .i_ext(ext), .i_ext_en(ext_en), .o_lvl(pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic set_pm(input p5g_pmode_t p);
    @(posedge clk);
    pm <= p;
  endtask

  task automatic report_and_stop;
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_reg(A_DATA, rv);   `CHK(rv, 8'h00)
    rd_reg(A_DIR, rv);    `CHK(rv, 8'hff)
    rd_reg(A_PULL, rv);   `CHK(rv, 8'h00)
    rd_reg(A_MODE, rv);   `CHK(rv, 8'h00)
    rd_reg(3'h6, rv);     `CHK(rv, 8'h00)
    `CHK(wake, 8'hff)
    `CHK(oe, 8'h00)
  endtask

  task automatic t_gpio;
    wr_reg(A_DIR, 8'hff);
    wr_reg(A_DATA, 8'ha5);
    rd_reg(A_DATA, rv);   `CHK(rv, 8'ha5)
    cyc(2);
    `CHK(out, 8'ha5)
    `CHK(oe, 8'hff)
    wr_reg(A_PULL, 8'hff);
    cyc(1);               `CHK(pull, 8'h00)
    ext <= 8'h3c;
    wr_reg(A_DIR, 8'h0f);
    cyc(5);
    `CHK(pull, 8'hf0)
    `CHK(oe, 8'h0f)
    rd_reg(A_DATA, rv);   `CHK(rv, 8'h35)
  endtask

  task automatic t_seg;
    wr_reg(A_PULL, 8'h00);
    wr_reg(A_DIR, 8'hff);
    wr_reg(A_DATA, 8'h00);
    wr_reg(A_MODE, 8'h0f);
    ext <= 8'h00;
    for (int f = 0; f < 16; f++) begin
      @(posedge clk);
      field <= 4'(f);
      m = ((f >= 2 && f <= 9) ? 8'hf0 : 8'h00) | ((f >= 1 && f <= 8) ? 8'h0f : 8'h00);
      cyc(6);
      `CHK(out, m & 8'h5a)
      `CHK(oe, m | 8'hf0)
      `CHK(wake, ~(8'h0f & ~m))
    end
    @(posedge clk);
    field <= 4'h0;
  endtask

  task automatic t_wake;
    ext <= 8'h01;
    wr_reg(A_MODE, 8'h01);
    wr_reg(A_DIR, 8'h01);
    wr_reg(A_MASK, 8'h00);
    cyc(5);
    wr_reg(A_STAT, 8'hff);
    cyc(0);
    `CHK(oe[0], 1'b0)
    ext <= 8'h00;
    cyc(6);
    `CHK(wake[0], 1'b0)
    `CHK(irq, 1'b0)
    rd_reg(A_STAT, rv);   `CHK(rv, 8'h01)
    wr_reg(A_MASK, 8'h01);
    cyc(1);               `CHK(irq, 1'b1)
    wr_reg(A_STAT, 8'h01);
    cyc(1);               `CHK(irq, 1'b0)
    wr_reg(A_MODE, 8'hff);
    cyc(2);               `CHK(oe, 8'h00)
    wr_reg(A_MODE, 8'h00);
  endtask

  task automatic t_rerun;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    cyc(2);
    `CHK(oe, 8'h00)
    rd_reg(A_DATA, rv);   `CHK(rv & 8'h00, 8'h00)
    rd_reg(A_PULL, rv);   `CHK(rv, 8'h00)
    rd_reg(A_MODE, rv);   `CHK(rv, 8'h00)
    `CHK(pull, 8'h00)
  endtask

  task automatic t_power;
    wr_reg(A_DIR, 8'hff);
    wr_reg(A_DATA, 8'ha5);
    wr_reg(A_PULL, 8'hf0);
    cyc(2);
    set_pm(PM_SLEEP);
    wr_reg(A_DATA, 8'h5a);
    cyc(2);
    `CHK(out, 8'ha5)
    `CHK(oe, 8'hff)
    set_pm(PM_STANDBY);
    ext_en <= 1'b0;
    cyc(1);               `CHK(oe, 8'h00)
    wr_reg(A_DIR, 8'h0f);
    cyc(1);               `CHK(pull, 8'hf0)
    set_pm(PM_ACTIVE);
    ext_en <= 1'b1;
    cyc(2);
    `CHK(out, 8'h5a)
    `CHK(oe, 8'h0f)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end

  initial begin
    failures = 0;
    num_checks = 0;
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    field = 4'h0;
    seg = 8'h5a;
    ext = 8'h00;
    ext_en = 1'b1;
    pm = PM_ACTIVE;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    cyc(4);
    t_reset;
    t_gpio;
    t_seg;
    t_wake;
    t_power;
    t_rerun;
    report_and_stop;
  end
endmodule
